/* shared/swcfg_pkg.sv */
package swcfg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Input population
   localparam int NUM_IN = 22;
   localparam int NUM_GROUND_SWITCH_INPUT = 14;
   localparam int NUM_PROGRAMMABLE_INPUT = 8;
   // Programmable inputs sit above the ground-switch inputs in every vector
   localparam int SP_BASE = 14;
   localparam int CODE_W = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame layout
   localparam int WORD_W = 24;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] FRAME_BITS = 6'h18;
   localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;
   localparam int OP_MSB = 23;
   localparam int OP_LSB = 16;
   localparam int ANA_CODE_LSB = 0;
   localparam int ANA_CUR_LSB = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Command codes in the top byte of a frame
   localparam logic [7:0] OP_STATUS = 8'h00;
   localparam logic [7:0] OP_SETTINGS = 8'h03;
   localparam logic [7:0] OP_CUR_SP = 8'h04;
   localparam logic [7:0] OP_CUR_SG = 8'h05;
   localparam logic [7:0] OP_WET_SP = 8'h06;
   localparam logic [7:0] OP_WET_SG = 8'h07;
   localparam logic [7:0] OP_TRI_SP = 8'h08;
   localparam logic [7:0] OP_TRI_SG = 8'h09;
   localparam logic [7:0] OP_ANALOG = 8'h0A;
   localparam logic [7:0] OP_SLEEP = 8'h0C;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [NUM_IN-1:0] RST_TRI = 22'h3FFFFF;
   localparam logic [NUM_PROGRAMMABLE_INPUT-1:0] RST_BATT = 8'h00;
   localparam logic [NUM_IN-1:0] RST_HI = 22'h000000;
   localparam logic [NUM_IN-1:0] RST_WET_OFF = 22'h000000;
   localparam logic [CODE_W-1:0] RST_ANA_CODE = 5'h1F;
   localparam logic [NUM_IN-1:0] RST_LEVEL = 22'h3FFFFF;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {
      SWCFG_ANA_HIZ  = 2'b00,
      SWCFG_ANA_LOW  = 2'b01,
      SWCFG_ANA_HIGH = 2'b10
   } swcfg_ana_cur_t;

   typedef enum logic {
      SWCFG_NORMAL = 1'b0,
      SWCFG_SLEEP  = 1'b1
   } swcfg_mode_t;

endpackage

/* core/swcfg_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module swcfg_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Asynchronous level in, synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // Two stages; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule // swcfg_sync

`default_nettype wire

/* core/swcfg_top.sv */
// Functional notes
// - Twenty-two-way analog selector, input chosen by binary code in analog command.
// - Requested analog input is routed only at chip select rising edge.
// - Analog-selected input reports zero in following serial output word.
// - Analog input current: high impedance, low pull-up or high pull-up.
// - After reset: normal mode, all inputs tri-stated, no source driving.
// - Programmable inputs source or sink according to battery/ground type setting.
// - Battery-type programmable input with tri-state off sinks toward ground.
// - Host toggles driver via settings; ground type sources, battery type sinks.
// - Ground-switch input not tri-stated sources pull-up; tri-stated turns off.
// - Tri-stated ground-switch input still sampled; low level reports one.
// - Chip select falling edge wakes device from sleep to normal.
// - Device acts only on frames framed by its own chip select.
// - Configuration commands accepted only in normal operating mode.
// - Daisy chain: output delays input by one frame, chain shifts 48 bits.
// - Sleep command takes effect at chip select rising edge.
`timescale 1ns/10ps
`default_nettype none

module swcfg_top
   import swcfg_pkg::*;
(
   // System clock and reset
   input wire logic clk,
   input wire logic srst,
   // Serial link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   output logic so,
   // Comparator levels, one per input
   input wire logic [swcfg_pkg::NUM_IN-1:0] sw_level,
   // Current source controls, one per input
   output logic [swcfg_pkg::NUM_IN-1:0] src_en,
   output logic [swcfg_pkg::NUM_IN-1:0] sink_en,
   output logic [swcfg_pkg::NUM_IN-1:0] high_current,
   output logic [swcfg_pkg::NUM_IN-1:0] wet_timer_off,
   // Analog selector and mode
   output logic [swcfg_pkg::CODE_W-1:0] analog_select_output,
   output logic analog_en,
   output logic sleep_mode
);
   import swcfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State types

   typedef struct packed {
      logic [WORD_W-1:0] sh;
      logic [CNT_W-1:0] cnt;
   } swcfg_link_t;

   typedef struct packed {
      swcfg_mode_t mode;
      logic cs_prev;
      logic frame_void;
      logic [NUM_IN-1:0] tri_st;
      logic [NUM_PROGRAMMABLE_INPUT-1:0] batt;
      logic [NUM_IN-1:0] hi_cfg;
      logic [NUM_IN-1:0] wet_off;
      logic ana_en;
      logic [CODE_W-1:0] ana_code;
      swcfg_ana_cur_t ana_cur;
      logic [WORD_W-1:0] status;
      logic [NUM_IN-1:0] src;
      logic [NUM_IN-1:0] sink;
      logic [NUM_IN-1:0] hi_out;
   } swcfg_state_t;

   swcfg_link_t link_q, link_d;
   swcfg_state_t st_q, st_d;
   logic so_q;
   logic first_q;
   logic cs_n_s;
   logic [NUM_IN-1:0] lvl_s;
   logic cs_rise, cs_fall, frame_ok, cmd_ok;
   logic [WORD_W-1:0] cmd;
   logic [7:0] cmd_op;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain, clocked by the host's serial clock

   // Chip select high only rearms the frame start; clearing the shift word
   // there would wipe the command before the system clock side can read it
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // The shift word holds still after a frame because the host parks its clock
   always_ff @(posedge sclk) begin
      link_q <= link_d;
   end

   // First edge loads the status word; later edges shift serial input in
   always_comb begin
      link_d = link_q;
      if (first_q) begin
         link_d.sh = {st_q.status[WORD_W-2:0], si};
         link_d.cnt = 6'h01;
      end else begin
         link_d.sh = {link_q.sh[WORD_W-2:0], si};
         if (link_q.cnt != CNT_MAX) begin
            link_d.cnt = link_q.cnt + 6'h01;
         end
      end
   end

   // Output changes on falling edges; the top status bit is always zero,
   // which is why the idle clear value is also the first bit sent
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         so_q <= 1'b0;
      end else begin
         so_q <= link_q.sh[WORD_W-1];
      end
   end

   assign so = so_q;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers into the system clock domain

   swcfg_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
      .clk(clk),
      .srst(srst),
      .d(cs_n),
      .q(cs_n_s)
   );

   swcfg_sync #(.W(NUM_IN), .RST_VAL(RST_LEVEL)) u_lvl_sync (
      .clk(clk),
      .srst(srst),
      .d(sw_level),
      .q(lvl_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame boundaries; the link word is static once chip select is high,
   // so it is read here only after the synchronised rising edge
   assign cs_rise = cs_n_s && !st_q.cs_prev;
   assign cs_fall = !cs_n_s && st_q.cs_prev;
   assign cmd = link_q.sh;
   assign cmd_op = cmd[OP_MSB:OP_LSB];
   assign frame_ok = link_q.cnt >= FRAME_BITS;
   assign cmd_ok = frame_ok && !st_q.frame_void && (st_q.mode == SWCFG_NORMAL);

   ////////////////////////////////////////////////////////////////////////////
   // Command decode, status build and current source drive
   always_comb begin
      logic is_ana;
      logic ground_type;
      logic [NUM_IN-1:0] batt_all;
      is_ana = 1'b0;
      ground_type = 1'b1;
      batt_all = '0;
      st_d = st_q;
      st_d.cs_prev = cs_n_s;

      // Falling edge of chip select wakes the part; that frame is void
      if (cs_fall) begin
         if (st_q.mode == SWCFG_SLEEP) begin
            st_d.mode = SWCFG_NORMAL;
            st_d.frame_void = 1'b1;
         end else begin
            st_d.frame_void = 1'b0;
         end
      end

      // Only a complete frame ending at our own chip select is acted on
      if (cs_rise && cmd_ok) begin
         case (cmd_op)
            OP_SETTINGS: begin
               st_d.batt = cmd[NUM_PROGRAMMABLE_INPUT-1:0];
            end
            OP_CUR_SP: begin
               st_d.hi_cfg[NUM_IN-1:SP_BASE] = cmd[NUM_PROGRAMMABLE_INPUT-1:0];
            end
            OP_CUR_SG: begin
               st_d.hi_cfg[SP_BASE-1:0] = cmd[NUM_GROUND_SWITCH_INPUT-1:0];
            end
            OP_WET_SP: begin
               st_d.wet_off[NUM_IN-1:SP_BASE] = cmd[NUM_PROGRAMMABLE_INPUT-1:0];
            end
            OP_WET_SG: begin
               st_d.wet_off[SP_BASE-1:0] = cmd[NUM_GROUND_SWITCH_INPUT-1:0];
            end
            OP_TRI_SP: begin
               st_d.tri_st[NUM_IN-1:SP_BASE] = cmd[NUM_PROGRAMMABLE_INPUT-1:0];
            end
            OP_TRI_SG: begin
               st_d.tri_st[SP_BASE-1:0] = cmd[NUM_GROUND_SWITCH_INPUT-1:0];
            end
            OP_ANALOG: begin
               // A code past the last input deselects the analog path
               st_d.ana_code = cmd[ANA_CODE_LSB +: CODE_W];
               st_d.ana_en = cmd[ANA_CODE_LSB +: CODE_W] < 5'(NUM_IN);
               st_d.ana_cur = swcfg_ana_cur_t'(cmd[ANA_CUR_LSB +: 2]);
            end
            OP_SLEEP: begin
               st_d.mode = SWCFG_SLEEP;
            end
            default: begin
               // Status read and unknown codes leave the setup alone
            end
         endcase
      end

      // Battery type spread over all inputs; ground-switch inputs never are
      batt_all = {st_d.batt, {NUM_GROUND_SWITCH_INPUT{1'b0}}};

      // Status word refreshes only while idle, so the link never sees it move
      if (cs_n_s) begin
         st_d.status = '0;
         for (int i = 0; i < NUM_IN; i++) begin
            ground_type = !batt_all[i];
            // Comparator is read whether or not the source is on
            st_d.status[i] = ground_type ? !lvl_s[i] : lvl_s[i];
            if (st_d.ana_en && (st_d.ana_code == 5'(i))) begin
               st_d.status[i] = 1'b0;
            end
         end
      end

      // Source and sink drive follow the configuration being latched
      for (int i = 0; i < NUM_IN; i++) begin
         is_ana = st_d.ana_en && (st_d.ana_code == 5'(i));
         ground_type = !batt_all[i];
         st_d.src[i] = 1'b0;
         st_d.sink[i] = 1'b0;
         st_d.hi_out[i] = st_d.hi_cfg[i];
         if (is_ana) begin
            st_d.src[i] = (st_d.ana_cur == SWCFG_ANA_LOW) ||
                          (st_d.ana_cur == SWCFG_ANA_HIGH);
            st_d.hi_out[i] = st_d.ana_cur == SWCFG_ANA_HIGH;
         end else if (!st_d.tri_st[i]) begin
            st_d.src[i] = ground_type;
            st_d.sink[i] = !ground_type;
         end
      end
   end

   // All control state in one register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.mode <= SWCFG_NORMAL;
         st_q.cs_prev <= 1'b1;
         st_q.tri_st <= RST_TRI;
         st_q.batt <= RST_BATT;
         st_q.hi_cfg <= RST_HI;
         st_q.wet_off <= RST_WET_OFF;
         st_q.ana_code <= RST_ANA_CODE;
         st_q.ana_cur <= SWCFG_ANA_HIZ;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs come straight from the state register
   assign src_en = st_q.src;
   assign sink_en = st_q.sink;
   assign high_current = st_q.hi_out;
   assign wet_timer_off = st_q.wet_off;
   assign analog_select_output = st_q.ana_code;
   assign analog_en = st_q.ana_en;
   assign sleep_mode = st_q.mode == SWCFG_SLEEP;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence frame_end_s;
      cs_rise && cmd_ok;
   endsequence

   sequence ana_cmd_s;
      frame_end_s ##0 (cmd_op == OP_ANALOG) && (cmd[4:0] < 5'h16);
   endsequence

   sequence sleep_cmd_s;
      frame_end_s ##0 (cmd_op == OP_SLEEP);
   endsequence

   ana_route_a: assert property (
      ana_cmd_s |=> analog_en && (analog_select_output == $past(cmd[4:0])))
      else $error("analog selection not applied at frame end");

   ana_zero_a: assert property (
      (analog_en && cs_n_s && st_q.cs_prev) |=> !st_q.status[$past(analog_select_output)])
      else $error("analog input not reported as zero");

   reset_tri_a: assert property (disable iff (1'b0)
      $past(srst) |-> (src_en == '0) && (sink_en == '0) && !sleep_mode)
      else $error("drive active or asleep after reset");

   sp_drive_a: assert property (
      (!st_q.tri_st[SP_BASE] && !(analog_en && analog_select_output == 5'h0E))
      |-> (sink_en[SP_BASE] == st_q.batt[0]) && (src_en[SP_BASE] == !st_q.batt[0]))
      else $error("programmable input drive direction wrong");

   sg_source_a: assert property (
      !(analog_en && analog_select_output == 5'h00)
      |-> (src_en[0] == !st_q.tri_st[0]) && !sink_en[0])
      else $error("ground-switch source does not follow tri-state");

   sg_sample_a: assert property (
      (cs_n_s && st_q.cs_prev && !lvl_s[1] && !(analog_en && analog_select_output == 5'h01))
      |=> st_q.status[1])
      else $error("low ground-switch level not reported as one");

   wake_up_a: assert property (
      (sleep_mode && cs_fall) |=> !sleep_mode ##1 !sleep_mode)
      else $error("chip select fall did not wake");

   sleep_enter_a: assert property (
      sleep_cmd_s |=> sleep_mode)
      else $error("sleep command not applied at frame end");

   asleep_ignore_a: assert property (
      (cs_rise && (sleep_mode || !frame_ok))
      |=> $stable(st_q.tri_st) && $stable(st_q.batt) && $stable(analog_select_output))
      else $error("command taken while asleep or short frame");

   latch_edge_a: assert property (
      !cs_rise |=> $stable(st_q.tri_st) && $stable(st_q.hi_cfg) && $stable(st_q.batt)
                   && $stable(st_q.wet_off) && $stable(analog_select_output))
      else $error("configuration changed away from frame end");

   void_drop_a: assert property (
      (cs_rise && st_q.frame_void)
      |=> $stable(st_q.tri_st) && $stable(st_q.batt) && $stable(analog_select_output))
      else $error("command taken from the waking frame");

   ana_deselect_a: assert property (
      (frame_end_s ##0 ((cmd_op == OP_ANALOG) && (cmd[4:0] >= 5'h16))) |=> !analog_en)
      else $error("out of range analog code left the path routed");

endmodule // swcfg_top

`default_nettype wire

/* verif/swcfg_host.sv */
`timescale 1ns/10ps
`default_nettype none

module swcfg_host (
   // Link pins driven by the host
   output logic sclk,
   output logic cs_n,
   output logic si,
   // Serial answer from the device
   input wire logic so
);
   logic [47:0] rsp;

   // Idle link: clock parked low, device deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      rsp = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One frame of n bits, first bit is d[n-1]; with mine low the select stays
   // high, so the traffic belongs to some other device on the bus
   task automatic frame(input int n, input logic [47:0] d, input bit mine);
      cs_n = ~mine;
      #120; // Status word must be frozen before the first edge
      for (int i = n - 1; i >= 0; i--) begin
         si = d[i];
         #6 sclk = 1'b1;
         rsp = {rsp[46:0], so};
         #6 sclk = 1'b0;
      end
      #6 cs_n = 1'b1;
      si = ~si; // Released line must not keep a stale value
      #150; // Long gap so the command lands before the next frame
   endtask
endmodule // swcfg_host

`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import swcfg_pkg::*;

   typedef struct {
      int sel;
      logic [31:0] exp;
   } swcfg_note_t;

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [NUM_IN-1:0] sw_level = '0;
   logic sclk, cs_n, si, so, analog_en, sleep_mode;
   logic [NUM_IN-1:0] src_en, sink_en, high_current, wet_timer_off;
   logic [CODE_W-1:0] analog_select_output;
   logic [CODE_W-1:0] code;
   logic [31:0] seed = 32'h00000E21;
   logic [31:0] pb = 32'h1 << (SP_BASE + 3);
   int err_count = 0;
   int total_checks = 0;
   swcfg_note_t notes[$];
   string names[7] = '{"src_en", "sink_en", "high_current", "wet_timer_off",
                       "analog", "sleep_mode", "so_word"};
   event look;

   // System clock, 25 ns
   always #12.5 clk = ~clk;

   swcfg_top DUT (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
      .sw_level(sw_level), .src_en(src_en), .sink_en(sink_en),
      .high_current(high_current), .wet_timer_off(wet_timer_off),
      .analog_select_output(analog_select_output), .analog_en(analog_en),
      .sleep_mode(sleep_mode));

   swcfg_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

   ////////////////////////////////////////////////////////////////////////////
   // Outputs are compared in arrival order against what the driver noted
   always @(look) begin
      while (notes.size() > 0) begin
         swcfg_note_t n;
         logic [31:0] seen;
         n = notes.pop_front();
         case (n.sel)
            0: seen = 32'(src_en);
            1: seen = 32'(sink_en);
            2: seen = 32'(high_current);
            3: seen = 32'(wet_timer_off);
            4: seen = {26'h0, analog_en, analog_select_output};
            5: seen = 32'(sleep_mode);
            default: seen = 32'(host.rsp[23:0]);
         endcase
         total_checks++;
         if (seen !== n.exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", names[n.sel], n.exp, seen);
         end
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic note(input int sel, input logic [31:0] exp);
      notes.push_back('{sel, exp});
      -> look;
      @(negedge clk);
   endtask

   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic cmd(input logic [7:0] op, input logic [15:0] pl);
      host.frame(24, {24'h0, op, pl}, 1'b1);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // A hang must still end in the verdict
   initial begin
      #300000;
      err_count++;
      final_report();
   end

   // Main sequence; the settle gap inside each frame covers the 2-3 clk latency
   initial begin
      do_reset();
      note(0, 32'h0);
      note(1, 32'h0);
      note(4, 32'(RST_ANA_CODE));
      note(5, 32'h0);
      @(posedge clk);
      seed = lfsr(seed);
      sw_level <= seed[NUM_IN-1:0];
      repeat (5) @(posedge clk);
      cmd(OP_STATUS, 16'h0000);
      note(6, {10'h0, ~sw_level});
      $display("test reset and status done");
      // Programmable input 3 as a gate driver, host sequence in order
      cmd(OP_WET_SP, 16'h0008);
      cmd(OP_CUR_SP, 16'h0008);
      cmd(OP_SETTINGS, 16'h0008);
      cmd(OP_TRI_SP, 16'h00F7);
      note(3, pb);
      note(1, pb);
      note(0, 32'h0);
      cmd(OP_STATUS, 16'h0000);
      note(6, {10'h0, ~sw_level ^ pb[21:0]});
      cmd(OP_SETTINGS, 16'h0000);
      note(0, pb);
      note(1, 32'h0);
      cmd(OP_SETTINGS, 16'h0008);
      note(0, 32'h0);
      note(1, pb);
      $display("test driver done");
      // Ground input 0 as a lamp driver switched by tri-state alone
      cmd(OP_WET_SG, 16'h0001);
      cmd(OP_CUR_SG, 16'h0001);
      cmd(OP_TRI_SG, 16'h3FFE);
      note(0, 32'h1);
      note(2, pb | 32'h1);
      cmd(OP_TRI_SG, 16'h3FFF);
      note(0, 32'h0);
      host.frame(16, {32'h0, 16'h3FFE}, 1'b1);
      note(0, 32'h0);
      host.frame(24, {24'h0, OP_TRI_SG, 16'h3FFE}, 1'b0);
      note(0, 32'h0);
      $display("test lamp done");
      // Sleep, then the waking frame is dropped and the next one applies
      cmd(OP_SLEEP, 16'h0000);
      note(5, 32'h1);
      cmd(OP_TRI_SG, 16'h3FFE);
      note(5, 32'h0);
      note(0, 32'h0);
      cmd(OP_TRI_SG, 16'h3FFE);
      note(0, 32'h1);
      $display("test sleep done");
      // Two-device chain: the first word passes through, the last one acts
      seed = lfsr(seed);
      host.frame(48, {seed[23:0], OP_TRI_SG, 16'h3FFF}, 1'b1);
      note(6, {8'h0, seed[23:0]});
      note(0, 32'h0);
      $display("test chain done");
      // Analog selection for every current setting
      for (int c = 0; c < 3; c++) begin
         do_reset();
         seed = lfsr(seed);
         code = 5'(seed % 22);
         cmd(OP_ANALOG, {9'h0, c[1:0], code});
         note(4, {26'h0, 1'b1, code});
         note(0, 32'(c != 0) << code);
         note(2, 32'(c == 2) << code);
         cmd(OP_STATUS, 16'h0000);
         note(6, {10'h0, ~sw_level & ~(22'h1 << code)});
      end
      cmd(OP_ANALOG, 16'h0016);
      note(4, 32'h00000016);
      $display("test analog done");
      final_report();
   end
endmodule // tb_top

`default_nettype wire
